/* File: design/serial_port_control.sv */
// Serial port control: registers, flags, requests and clock pin steering.
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module serial_port_control (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       standby,
   // Register port.
   input  wire logic [2:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic [7:0]      rdata_ff,
   // Datapath events.
   input  wire logic       half_bit_tick,
   input  wire logic       tx_loaded,
   input  wire logic       tx_char_end,
   input  wire logic       rx_char_done,
   input  wire logic [7:0] rx_char,
   input  wire logic       rx_mp_bit,
   input  wire logic       rx_frame_err,
   input  wire logic       rx_parity_err,
   // Datapath controls.
   output logic [7:0]      mode_ff,
   output logic [7:0]      tx_data_ff,
   output logic            tx_go_ff,
   output logic            rx_start_ff,
   output logic            ext_clk_ff,
   // Pins.
   input  wire logic       rxd_pin,
   input  wire logic       sck_in,
   output logic            sck_out_ff,
   output logic            sck_oe_ff,
   // Requests.
   output logic            tx_empty_irq_ff,
   output logic            rx_full_irq_ff,
   output logic            rx_error_irq_ff,
   output logic            tx_end_irq_ff
);
   import serial_port_control_pkg::*;

   logic [7:0] ctrl_ff;
   logic [7:0] status_ff;
   logic [7:0] nxt_status;
   logic [7:0] armed_ff;
   logic [7:0] rx_buf_ff;
   logic [1:0] rxd_sync_ff;
   logic [1:0] sck_sync_ff;
   logic       rxd_q_ff;
   logic       sck_q_ff;
   logic       wr_ctrl;
   logic       wr_stat;
   logic       mp_active;
   logic       rx_accept;
   logic       sw_clr_tx_holding_empty_flag;
   logic       rx_err_any;

   assign wr_ctrl = wr && (addr == OFS_CTRL);
   assign wr_stat = wr && (addr == OFS_STATUS);
   // The wake filter only means something in asynchronous multiprocessor format.
   assign mp_active = ctrl_ff[CT_MULTIPROC_IRQ_ENABLE] && !mode_ff[MD_SYNC] && mode_ff[MD_MP];
   assign rx_accept = rx_char_done && !(mp_active && !rx_mp_bit);
   assign sw_clr_tx_holding_empty_flag = wr_stat && !wdata[ST_TX_HOLDING_EMPTY_FLAG] && armed_ff[ST_TX_HOLDING_EMPTY_FLAG];
   assign rx_err_any = status_ff[ST_OVERRUN_FLAG] || status_ff[ST_FER] || status_ff[ST_PER];

   // Control register; software always reaches it.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= CTRL_RST;
      end else if (standby) begin
         ctrl_ff <= CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_ff <= wdata;
         if (rx_char_done && mp_active && rx_mp_bit && wdata[CT_MULTIPROC_IRQ_ENABLE]) begin
            ctrl_ff[CT_MULTIPROC_IRQ_ENABLE] <= 1'b0;
         end
      end else if (rx_char_done && mp_active && rx_mp_bit) begin
         ctrl_ff[CT_MULTIPROC_IRQ_ENABLE] <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_ff <= MODE_RST;
      end else if (standby) begin
         mode_ff <= MODE_RST;
      end else if (wr && (addr == OFS_MODE)) begin
         mode_ff <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_data_ff <= DATA_RST;
      end else if (wr && (addr == OFS_TXDATA)) begin
         tx_data_ff <= wdata;
      end
   end

   // A flag may be cleared only after it was read as one; the complete flag clears once the empty flag was read as one.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         armed_ff <= 8'h00;
      end else if (standby || wr_stat) begin
         armed_ff <= 8'h00;
      end else if (rd && (addr == OFS_STATUS)) begin
         armed_ff <= armed_ff | status_ff;
      end
   end

   // Status flags. Hardware sets win over software clears in the same cycle.
   always_comb begin
      nxt_status = status_ff;
      if (wr_stat) begin
         for (int i = ST_PER; i <= ST_TX_HOLDING_EMPTY_FLAG; i++) begin
            if (!wdata[i] && armed_ff[i]) begin
               nxt_status[i] = 1'b0;
            end
         end
         nxt_status[ST_MPBT] = wdata[ST_MPBT];
         if (sw_clr_tx_holding_empty_flag) begin
            nxt_status[ST_TX_COMPLETE_FLAG] = 1'b0;
         end
      end
      if (tx_loaded) begin
         nxt_status[ST_TX_HOLDING_EMPTY_FLAG] = 1'b1;
      end
      if (tx_char_end && status_ff[ST_TX_HOLDING_EMPTY_FLAG]) begin
         nxt_status[ST_TX_COMPLETE_FLAG] = 1'b1;
      end
      if (rx_accept) begin
         if (mode_ff[MD_MP] && !mode_ff[MD_SYNC]) begin
            nxt_status[ST_MPB] = rx_mp_bit;
         end
         if (status_ff[ST_RX_BUFFER_FULL_FLAG]) begin
            nxt_status[ST_OVERRUN_FLAG] = 1'b1;
         end else if (rx_frame_err && !mode_ff[MD_SYNC]) begin
            nxt_status[ST_FER] = 1'b1;
         end else if (rx_parity_err && mode_ff[MD_PE] && !mode_ff[MD_MP]
                      && !mode_ff[MD_SYNC]) begin
            nxt_status[ST_PER] = 1'b1;
         end else begin
            nxt_status[ST_RX_BUFFER_FULL_FLAG] = 1'b1;
         end
      end
      if (!ctrl_ff[CT_TE]) begin
         nxt_status[ST_TX_HOLDING_EMPTY_FLAG] = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_ff <= STATUS_RST;
      end else if (standby) begin
         status_ff <= STATUS_RST;
      end else begin
         status_ff <= nxt_status;
      end
   end

   // Receive buffer; a framing error still delivers the character.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_buf_ff <= DATA_RST;
      end else if (rx_accept && !status_ff[ST_RX_BUFFER_FULL_FLAG]) begin
         rx_buf_ff <= rx_char;
      end
   end

   // Transmission may proceed only once software has cleared the empty flag.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_go_ff <= 1'b0;
      end else begin
         tx_go_ff <= ctrl_ff[CT_TE] && !status_ff[ST_TX_HOLDING_EMPTY_FLAG];
      end
   end

   // Pin inputs pass two flops before any edge detection.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxd_sync_ff <= 2'b11;
         sck_sync_ff <= 2'b11;
         rxd_q_ff <= 1'b1;
         sck_q_ff <= 1'b1;
      end else begin
         rxd_sync_ff <= {rxd_sync_ff[0], rxd_pin};
         sck_sync_ff <= {sck_sync_ff[0], sck_in};
         rxd_q_ff <= rxd_sync_ff[1];
         sck_q_ff <= sck_sync_ff[1];
      end
   end

   // Start of reception: falling data line, or falling external clock when synchronous.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_start_ff <= 1'b0;
      end else if (!ctrl_ff[CT_RE]) begin
         rx_start_ff <= 1'b0;
      end else if (mode_ff[MD_SYNC]) begin
         rx_start_ff <= ctrl_ff[CT_CLK_SOURCE_SEL] && sck_q_ff && !sck_sync_ff[1];
      end else begin
         rx_start_ff <= rxd_q_ff && !rxd_sync_ff[1];
      end
   end

   // Clock pin steering. The output clock toggles on each half bit time.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_clk_ff <= 1'b0;
         sck_oe_ff <= 1'b0;
         sck_out_ff <= 1'b1;
      end else begin
         ext_clk_ff <= ctrl_ff[CT_CLK_SOURCE_SEL];
         sck_oe_ff <= !ctrl_ff[CT_CLK_SOURCE_SEL]
                      && (mode_ff[MD_SYNC] || ctrl_ff[CT_CLK_OUTPUT_SEL]);
         if (!sck_oe_ff) begin
            sck_out_ff <= 1'b1;
         end else if (half_bit_tick) begin
            sck_out_ff <= !sck_out_ff;
         end
      end
   end

   // Requests are registered so that each output comes from a flop.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_empty_irq_ff <= 1'b0;
         rx_full_irq_ff <= 1'b0;
         rx_error_irq_ff <= 1'b0;
         tx_end_irq_ff <= 1'b0;
      end else begin
         tx_empty_irq_ff <= status_ff[ST_TX_HOLDING_EMPTY_FLAG] && ctrl_ff[CT_TIE];
         rx_full_irq_ff <= status_ff[ST_RX_BUFFER_FULL_FLAG] && ctrl_ff[CT_RIE];
         rx_error_irq_ff <= rx_err_any && ctrl_ff[CT_RIE];
         tx_end_irq_ff <= status_ff[ST_TX_COMPLETE_FLAG] && ctrl_ff[CT_TX_END_IRQ_ENABLE];
      end
   end

   // Read data stand in the cycle after the strobe only; unmapped reads give zero.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= 8'h00;
      end else if (!rd) begin
         rdata_ff <= 8'h00;
      end else if (addr == OFS_MODE) begin
         rdata_ff <= mode_ff;
      end else if (addr == OFS_CTRL) begin
         rdata_ff <= ctrl_ff;
      end else if (addr == OFS_STATUS) begin
         rdata_ff <= status_ff;
      end else if (addr == OFS_TXDATA) begin
         rdata_ff <= tx_data_ff;
      end else if (addr == OFS_RXDATA) begin
         rdata_ff <= rx_buf_ff;
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_wake;
      rx_char_done && mp_active && rx_mp_bit && !standby && !wr_ctrl;
   endsequence
   sequence s_idle_char;
      rx_char_done && mp_active && !rx_mp_bit && !wr_stat && !standby;
   endsequence

   // Read data appear only in the cycle after the strobe, so a stale value cannot be
   // mistaken for a fresh read.
   sequence s_ctrl_read;
      rd && (addr == OFS_CTRL);
   endsequence

   sequence s_line_fall;
      ctrl_ff[CT_RE] && !mode_ff[MD_SYNC] && rxd_q_ff && !rxd_sync_ff[1];
   endsequence

   // A clean character is one that none of the error branches can claim.
   sequence s_clean_char;
      rx_accept && !status_ff[ST_RX_BUFFER_FULL_FLAG] && !rx_frame_err && !standby
         && (mode_ff[MD_SYNC] || !mode_ff[MD_PE] || mode_ff[MD_MP] || !rx_parity_err);
   endsequence

   sequence s_tx_holding_empty_flag_clear;
      sw_clr_tx_holding_empty_flag && !tx_char_end && !standby;
   endsequence

   sequence s_clk_half;
      sck_oe_ff && half_bit_tick;
   endsequence

   AST_CTRL_STANDBY: assert property (standby |=> ctrl_ff == CTRL_RST)
      else $error("control register not cleared by standby");
   AST_TX_HOLDING_EMPTY_FLAG_LOCK: assert property (!ctrl_ff[CT_TE] && !standby |=> status_ff[ST_TX_HOLDING_EMPTY_FLAG])
      else $error("empty flag not held while transmit disabled");
   AST_TXI: assert property (status_ff[ST_TX_HOLDING_EMPTY_FLAG] && ctrl_ff[CT_TIE] |=> tx_empty_irq_ff)
      else $error("transmit empty request missing");
   AST_TXI_DROP: assert property (!ctrl_ff[CT_TIE] |=> !tx_empty_irq_ff)
      else $error("transmit empty request not withdrawn");
   AST_RX_IRQ: assert property (##1 rx_error_irq_ff == $past(rx_err_any && ctrl_ff[CT_RIE]))
      else $error("receive error request wrong");
   AST_TEI: assert property (##1 tx_end_irq_ff == $past(status_ff[ST_TX_COMPLETE_FLAG] && ctrl_ff[CT_TX_END_IRQ_ENABLE]))
      else $error("transmit end request wrong");
   AST_RE_KEEP: assert property (!ctrl_ff[CT_RE] && !rx_char_done && !wr_stat && !standby
      |=> $stable(status_ff[ST_PER +: 4]))
      else $error("receive flags changed while idle");
   AST_MP_FILTER: assert property (s_idle_char |=> $stable(rx_buf_ff)
      && status_ff[ST_RX_BUFFER_FULL_FLAG] == $past(status_ff[ST_RX_BUFFER_FULL_FLAG]))
      else $error("filtered character reached the buffer");
   AST_MP_WAKE: assert property (s_wake |=> !ctrl_ff[CT_MULTIPROC_IRQ_ENABLE] && status_ff[ST_MPB])
      else $error("wake character not handled");
   AST_SCK_EXT: assert property (ctrl_ff[CT_CLK_SOURCE_SEL] |=> !sck_oe_ff ##1 sck_out_ff)
      else $error("clock pin driven with external clock");
   AST_GO: assert property (ctrl_ff[CT_TE] && !status_ff[ST_TX_HOLDING_EMPTY_FLAG] |=> tx_go_ff)
      else $error("transmission not released");

   // Checks on the register port and the mode register standby clear.
   AST_RDATA_IDLE: assert property (!rd |=> rdata_ff == 8'h00)
      else $error("read data present without a read");

   AST_RDATA_CTRL: assert property (s_ctrl_read |=> rdata_ff == $past(ctrl_ff))
      else $error("control register read back wrong");

   AST_MODE_STANDBY: assert property (standby |=> mode_ff == MODE_RST)
      else $error("mode register not cleared by standby");

   // Checks on the requests, the transmit flags and the transmission release.
   AST_RXI: assert property (status_ff[ST_RX_BUFFER_FULL_FLAG] && ctrl_ff[CT_RIE] |=> rx_full_irq_ff)
      else $error("receive full request missing");

   AST_ERI: assert property (rx_err_any && ctrl_ff[CT_RIE] |=> rx_error_irq_ff)
      else $error("receive error request missing");

   AST_RXI_DROP: assert property (!ctrl_ff[CT_RIE] |=> !rx_full_irq_ff && !rx_error_irq_ff)
      else $error("receive requests not withdrawn");

   AST_TEI_DROP: assert property (!ctrl_ff[CT_TX_END_IRQ_ENABLE] |=> !tx_end_irq_ff)
      else $error("transmit end request not withdrawn");

   AST_TX_COMPLETE_FLAG_CLR: assert property (s_tx_holding_empty_flag_clear |=> !status_ff[ST_TX_COMPLETE_FLAG])
      else $error("complete flag not cleared with the empty flag");

   AST_TX_HOLDING_EMPTY_FLAG_SET: assert property (tx_loaded && !standby |=> status_ff[ST_TX_HOLDING_EMPTY_FLAG])
      else $error("empty flag not set on load");

   AST_GO_HOLD: assert property (!ctrl_ff[CT_TE] |=> !tx_go_ff)
      else $error("transmission released while disabled");

   // Checks on reception.
   AST_START_ASYNC: assert property (s_line_fall |=> rx_start_ff)
      else $error("start bit not detected");

   AST_START_OFF: assert property (!ctrl_ff[CT_RE] |=> !rx_start_ff)
      else $error("reception started while disabled");

   AST_RX_BUFFER_FULL_FLAG_SET: assert property (s_clean_char
      |=> status_ff[ST_RX_BUFFER_FULL_FLAG] && rx_buf_ff == $past(rx_char))
      else $error("clean character not delivered");

   AST_MP_FLAGS: assert property (s_idle_char |=> $stable(status_ff[ST_PER +: 4]))
      else $error("filtered character touched the receive flags");

   // Checks on the clock pin.
   AST_EXT_CLK: assert property (##1 ext_clk_ff == $past(ctrl_ff[CT_CLK_SOURCE_SEL]))
      else $error("external clock select not followed");

   AST_OE_SYNC: assert property (mode_ff[MD_SYNC] && !ctrl_ff[CT_CLK_SOURCE_SEL] |=> sck_oe_ff)
      else $error("synchronous clock output not driven");

   AST_OE_GPIO: assert property (!mode_ff[MD_SYNC] && !ctrl_ff[CT_CLK_SOURCE_SEL] && !ctrl_ff[CT_CLK_OUTPUT_SEL]
      |=> !sck_oe_ff)
      else $error("clock pin driven while free for general use");

   AST_SCK_IDLE: assert property (!sck_oe_ff |=> sck_out_ff)
      else $error("clock output not parked high");

   // A toggle per half bit keeps the output at the bit rate.
   AST_SCK_TOGGLE: assert property (s_clk_half |=> sck_out_ff != $past(sck_out_ff))
      else $error("clock output did not toggle");

endmodule : serial_port_control

/* File: design/serial_port_control_pkg.sv */
// Constants shared by the serial port control logic.
// Function
// - Control register always read/write, cleared by reset and standby.
// - Bit 7 enables the transmit-empty request raised when holding data moves out.
// - Transmit-empty request drops on read-one-write-zero of the empty flag or enable clear.
// - Bit 6 enables both receive-full and receive-error requests.
// - Receive requests drop when a receive flag is read-then-cleared or enable clears.
// - While transmit enable is 0 the holding-empty flag is held at 1.
// - Transmission starts once the empty flag is cleared after new data.
// - Clearing receive enable leaves the receive flags unchanged.
// - Reception starts on a start bit, or on incoming clock in synchronous mode.
// - Multiprocessor enable acts only in asynchronous mode with multiprocessor format.
// - While active, characters without the wake bit are dropped silently.
// - A wake character sets the wake flag, clears the enable, resumes receiving.
// - Bit 2 enables the end request raised when the last bit leaves empty.
// - End request drops on read-then-clear of empty flag, also clearing complete flag.
// - Selects 00 and 01 use the internal clock with the listed pin use.
// - Clock source select 1 takes the clock from the pin in both modes.
// - Clock output select acts only in asynchronous mode with internal clock.
// - Asynchronous clock output runs at the bit rate.
// - Mode bit 7 selects asynchronous at 0, synchronous at 1.
// - Multiprocessor format makes the parity settings ignored.
// - The empty flag sets when holding data loads into the shift register.
package serial_port_control_pkg;
   localparam logic [2:0] OFS_MODE   = 3'h0;
   localparam logic [2:0] OFS_CTRL   = 3'h1;
   localparam logic [2:0] OFS_STATUS = 3'h2;
   localparam logic [2:0] OFS_TXDATA = 3'h3;
   localparam logic [2:0] OFS_RXDATA = 3'h4;
   localparam logic [7:0] MODE_RST   = 8'h00;
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [7:0] STATUS_RST = 8'h84;
   localparam logic [7:0] DATA_RST   = 8'h00;
   // Control bits.
   localparam int CT_TIE  = 7;
   localparam int CT_RIE  = 6;
   localparam int CT_TE   = 5;
   localparam int CT_RE   = 4;
   localparam int CT_MULTIPROC_IRQ_ENABLE = 3;
   localparam int CT_TX_END_IRQ_ENABLE = 2;
   localparam int CT_CLK_SOURCE_SEL = 1;
   localparam int CT_CLK_OUTPUT_SEL = 0;
   // Mode bits.
   localparam int MD_SYNC = 7;
   localparam int MD_PE   = 5;
   localparam int MD_MP   = 2;
   // Status bits.
   localparam int ST_TX_HOLDING_EMPTY_FLAG = 7;
   localparam int ST_RX_BUFFER_FULL_FLAG = 6;
   localparam int ST_OVERRUN_FLAG = 5;
   localparam int ST_FER  = 4;
   localparam int ST_PER  = 3;
   localparam int ST_TX_COMPLETE_FLAG = 2;
   localparam int ST_MPB  = 1;
   localparam int ST_MPBT = 0;
endpackage : serial_port_control_pkg

/* File: testbench/serial_station.sv */
// Behavioural remote station driving the receive line and the external serial clock.
`timescale 1ns/10ps
module serial_station #(
   parameter real HALF_NS = 62.5
) (
   // Bench control.
   input  wire logic       go,
   input  wire logic       sync_mode,
   input  wire logic [7:0] data,
   // Line side.
   output logic            rxd,
   output logic            sck,
   output logic            busy
);
   initial begin
      rxd  = 1'b1;
      sck  = 1'b1;
      busy = 1'b0;
   end
   // The clock stands at 1 between frames and the line idles high, as a pulled-up line does.
   always @(posedge go) begin
      busy = 1'b1;
      if (sync_mode) begin
         for (int b = 0; b < 8; b++) begin
            sck = 1'b0;
            rxd = data[b];
            #HALF_NS sck = 1'b1;
            #HALF_NS;
         end
      end else begin
         for (int b = 0; b < 10; b++) begin
            rxd = (b == 0) ? 1'b0 : (b == 9) ? 1'b1 : data[b-1];
            repeat (16) begin
               #HALF_NS sck = 1'b0;
               #HALF_NS sck = 1'b1;
            end
         end
      end
      rxd  = 1'b1;
      busy = 1'b0;
   end
endmodule : serial_station

/* File: testbench/tb.sv */
// Self-checking bench for the serial port control block.
`timescale 1ns/10ps
module tb;
   import serial_port_control_pkg::*;
   logic       clk, rst_n, standby, wr, rd, half_bit_tick, tx_loaded, tx_char_end, go;
   logic       rx_char_done, rx_mp_bit, rx_frame_err, rx_parity_err, rxd_pin, sck_in;
   logic       tx_go_ff, rx_start_ff, ext_clk_ff, sck_out_ff, sck_oe_ff, line_sync, busy, e;
   logic       tx_empty_irq_ff, rx_full_irq_ff, rx_error_irq_ff, tx_end_irq_ff;
   logic [2:0] addr;
   logic [7:0] wdata, rdata_ff, mode_ff, tx_data_ff, rx_char, v, c, pdata;
   int         n_fail, comparisons, seen;
   serial_port_control dut (.clk, .rst_n, .standby, .addr, .wdata, .wr, .rd, .rdata_ff,
      .half_bit_tick, .tx_loaded, .tx_char_end, .rx_char_done, .rx_char, .rx_mp_bit,
      .rx_frame_err, .rx_parity_err, .mode_ff, .tx_data_ff, .tx_go_ff, .rx_start_ff,
      .ext_clk_ff, .rxd_pin, .sck_in, .sck_out_ff, .sck_oe_ff, .tx_empty_irq_ff,
      .rx_full_irq_ff, .rx_error_irq_ff, .tx_end_irq_ff);
   serial_station peer (.go, .sync_mode(line_sync), .data(pdata), .rxd(rxd_pin), .sck(sck_in),
      .busy);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic print_verdict();
      if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic idle();
      repeat (3) @(posedge clk);
      #1;
   endtask : idle
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 d = rdata_ff;
   endtask : rd_reg
   // A status clear only counts after the flag was read as 1, so every clear reads first.
   task automatic rclr(input logic [7:0] d);
      rd_reg(OFS_STATUS, v);
      wr_reg(OFS_STATUS, d);
      idle();
   endtask : rclr
   task automatic pulse(input int k);
      @(posedge clk);
      tx_loaded     <= (k == 0);
      tx_char_end   <= (k == 1);
      rx_char_done  <= (k == 2);
      half_bit_tick <= (k == 3);
      @(posedge clk);
      {tx_loaded, tx_char_end, rx_char_done, half_bit_tick} <= 4'h0;
      idle();
   endtask : pulse
   task automatic rxc(input logic [7:0] ch, input logic mp, input logic fe);
      rx_char       <= ch;
      rx_mp_bit     <= mp;
      rx_frame_err  <= fe;
      rx_parity_err <= 1'($urandom);
      pulse(2);
   endtask : rxc
   task automatic frame(input logic s);
      line_sync <= s;
      pdata     <= 8'($urandom);
      go        <= 1'b1;
      seen = 0;
      @(posedge clk);
      go <= 1'b0;
      // Only the first falling clock edge of a synchronous frame falls inside this window.
      repeat (20) begin
         @(posedge clk);
         #1;
         if (rx_start_ff === 1'b1) seen++;
      end
      chk(8'(seen), 8'h01);
      for (int k = 0; k < 8000 && busy; k++) @(posedge clk);
   endtask : frame
   function automatic logic exp_oe(input logic sync, input logic [1:0] cke);
      return !cke[1] && (sync || cke[0]);
   endfunction : exp_oe
   initial begin
      repeat (30000) @(posedge clk);
      n_fail++;
      print_verdict();
   end
   initial begin
      {standby, wr, rd, half_bit_tick, tx_loaded, tx_char_end, rx_char_done, go} = '0;
      {rx_mp_bit, rx_frame_err, rx_parity_err, line_sync, addr, wdata, rx_char, pdata} = '0;
      rst_n = 1'b0;
      n_fail = 0;
      comparisons = 0;
      void'($urandom(26430));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(OFS_CTRL, v);
      chk(v, CTRL_RST);
      for (int i = 0; i < 4; i++) begin
         c = 8'($urandom);
         wr_reg(OFS_CTRL, c);
         rd_reg(OFS_CTRL, v);
         chk(v, c);
      end
      c = 8'($urandom);
      wr_reg(OFS_MODE, c);
      idle();
      chk(mode_ff, c);
      @(posedge clk) standby <= 1'b1;
      @(posedge clk) standby <= 1'b0;
      rd_reg(OFS_CTRL, v);
      chk(v, CTRL_RST);
      chk(mode_ff, MODE_RST);
      rclr(8'h00);
      rd_reg(OFS_STATUS, v);
      chk(v[ST_TX_HOLDING_EMPTY_FLAG], 1'b1);
      c = 8'($urandom);
      wr_reg(OFS_TXDATA, c);
      wr_reg(OFS_CTRL, 8'ha4);
      idle();
      chk(tx_data_ff, c);
      chk({tx_empty_irq_ff, tx_end_irq_ff, tx_go_ff}, 3'h4);
      rclr(8'h00);
      chk({tx_empty_irq_ff, tx_end_irq_ff, tx_go_ff}, 3'h1);
      pulse(0);
      chk({tx_empty_irq_ff, tx_go_ff}, 2'h2);
      pulse(1);
      chk(tx_end_irq_ff, 1'b1);
      wr_reg(OFS_CTRL, 8'h20);
      idle();
      chk({tx_empty_irq_ff, tx_end_irq_ff}, 2'h0);
      // From here on the format is set before the enables or the clock selects are written.
      wr_reg(OFS_MODE, 8'h00);
      wr_reg(OFS_CTRL, 8'h50);
      c = 8'($urandom);
      rxc(c, 1'b0, 1'b0);
      chk(rx_full_irq_ff, 1'b1);
      rd_reg(OFS_RXDATA, v);
      chk(v, c);
      wr_reg(OFS_CTRL, 8'h40);
      rclr(8'h00);
      chk(v[ST_RX_BUFFER_FULL_FLAG], 1'b1);
      chk(rx_full_irq_ff, 1'b0);
      wr_reg(OFS_CTRL, 8'h50);
      rxc(8'($urandom), 1'b0, 1'b1);
      chk(rx_error_irq_ff, 1'b1);
      wr_reg(OFS_CTRL, 8'h10);
      idle();
      chk(rx_error_irq_ff, 1'b0);
      rclr(8'h00);
      wr_reg(OFS_MODE, 8'h04);
      wr_reg(OFS_CTRL, 8'h58);
      rxc(8'($urandom), 1'b0, 1'b0);
      chk(rx_full_irq_ff, 1'b0);
      rxc(8'($urandom), 1'b1, 1'b0);
      rd_reg(OFS_CTRL, c);
      chk({rx_full_irq_ff, c[CT_MULTIPROC_IRQ_ENABLE]}, 2'h2);
      rclr(8'h00);
      chk(v[ST_MPB], 1'b1);
      wr_reg(OFS_MODE, 8'h84);
      wr_reg(OFS_CTRL, 8'h58);
      rxc(8'($urandom), 1'b0, 1'b0);
      chk(rx_full_irq_ff, 1'b1);
      rclr(8'h00);
      for (int i = 0; i < 8; i++) begin
         wr_reg(OFS_MODE, {i[2], 7'h00});
         wr_reg(OFS_CTRL, {6'h00, i[1:0]});
         idle();
         chk({sck_oe_ff, ext_clk_ff}, {exp_oe(i[2], i[1:0]), i[1]});
      end
      wr_reg(OFS_MODE, 8'h00);
      wr_reg(OFS_CTRL, 8'h01);
      idle();
      e = sck_out_ff;
      for (int i = 0; i < 4; i++) begin
         pulse(3);
         e = ~e;
         chk(sck_out_ff, e);
      end
      wr_reg(OFS_CTRL, 8'h10);
      frame(1'b0);
      wr_reg(OFS_MODE, 8'h80);
      wr_reg(OFS_CTRL, 8'h12);
      frame(1'b1);
      print_verdict();
   end
endmodule : tb
